//--- pkg/nvc_pkg.sv
/*
 shared constants for the nonvolatile access controller: apb offsets, control bit
 positions, unlock pattern, flash geometry, protect limits, timing counts, state types.
 assumes a 125 MHz pclk and an 8-bit apb byte address.
*/
package nvc_pkg;
	// apb byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_UNLOCK = 8'h04;
	localparam logic [7:0] OFF_DLO    = 8'h08;
	localparam logic [7:0] OFF_DHI    = 8'h0c;
	localparam logic [7:0] OFF_ALO    = 8'h10;
	localparam logic [7:0] OFF_AHI    = 8'h14;
	localparam logic [7:0] OFF_IRQ    = 8'h18;
	localparam logic [7:0] OFF_STAT   = 8'h1c;
	// nv_control bit positions
	localparam int B_RD    = 0;
	localparam int B_WR    = 1;
	localparam int B_WALW  = 2;
	localparam int B_ABORT = 3;
	localparam int B_FREE  = 4;
	localparam int B_LATCH = 5;
	localparam int B_CSEL  = 6;
	localparam int B_SPACE = 7;
	// unlock pattern
	localparam logic [7:0] UNLOCK_A = 8'h55;
	localparam logic [7:0] UNLOCK_B = 8'haa;
	// flash geometry and latch erase value
	localparam int          LATCHES   = 8;
	localparam logic [13:0] LATCH_RST = 14'h3fff;
	// self-write protect limits: addresses below the limit are protected
	localparam logic [15:0] PROT_NONE = 16'h0000;
	localparam logic [15:0] PROT_LOW  = 16'h0200;
	localparam logic [15:0] PROT_HALF = 16'h1000;
	localparam logic [15:0] PROT_ALL  = 16'h8000;
	// timing
	localparam int CLK_MHZ     = 125;
	localparam int PWRT_MS     = 64;
	localparam int FLWR_US     = 2000;
	localparam int EEWR_US     = 4000;
	localparam int PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
	localparam int FLWR_CYCLES = FLWR_US * CLK_MHZ;
	localparam int EEWR_CYCLES = EEWR_US * CLK_MHZ;
	localparam int CNT_W       = 23;
	// state types
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_EE   = 2'b01,
		OP_FL   = 2'b11
	} nvc_op_t;
	typedef enum logic [1:0] {
		UL_IDLE  = 2'b00,
		UL_FIRST = 2'b01,
		UL_ARMED = 2'b11
	} nvc_ulk_t;
endpackage : nvc_pkg

//--- pkg/nvc_ee_if.sv
/*
 port between the controller and the eeprom byte array: one write port, one cpu
 read port, one programmer read port. assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface nvc_ee_if;
	logic       we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;
	logic [7:0] xaddr;
	logic [7:0] xdata;
	modport ctl (output we, waddr, wdata, raddr, xaddr, input rdata, xdata);
	modport mem (input we, waddr, wdata, raddr, xaddr, output rdata, xdata);
endinterface : nvc_ee_if

//--- hw/nvc_ee_array.sv
/*
 data eeprom byte array in flip-flops with combinational read ports.
 assumes the controller holds address and data stable while we is high.
*/
`timescale 1ns/1ps
module nvc_ee_array (
	// clock
	input wire logic pclk,
	// array port
	nvc_ee_if.mem    ee
);
	// nonvolatile contents, so no reset
	logic [7:0] mem_reg [0:255];

	always_ff @(posedge pclk) begin
		if (ee.we) begin
			mem_reg[ee.waddr] <= ee.wdata; // see [RULE_03]
		end
	end

	assign ee.rdata = mem_reg[ee.raddr]; // see [RULE_01]
	assign ee.xdata = mem_reg[ee.xaddr];
endmodule : nvc_ee_array

//--- hw/nvc_ctrl.sv
/*
 nonvolatile access controller: apb register file, unlock sequence, eeprom and flash
 commit timing, flash write latches, protection gating and programmer read path.
 assumes an apb master, a flash macro that answers flash_rdata combinationally from
 flash_addr, and dev_reset as a synchronous non-power-up reset request.
*/
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// [RULE_01] eeprom holds 256 bytes at 8-bit addresses 0h to 0ffh
// [RULE_02] flash words are 14 bits; the address pair forms a 15-bit word address
// [RULE_03] an eeprom byte write erases then programs with no separate erase
// [RULE_04] flash reads always work; writes and erases skip protected regions
// [RULE_05] code protect blocks programmer reads of both memories, cpu unaffected
// [RULE_06] space select clear picks eeprom, set picks flash, resets to eeprom
// [RULE_07] read and commit strobes ignore written zeros; hardware clears them
// [RULE_08] write allow clears on power-up only; clearing it spares a running write
// [RULE_09] commit strobe stays clear when write allow is clear
// [RULE_10] reset during a running write sets the abort flag
// [RULE_11] write completion sets the done flag; firmware must clear it
// [RULE_12] the unlock port reads as zero and only takes the unlock pattern
// [RULE_13] only 55h then aah then commit, per byte, starts a write
// [RULE_14] eeprom read data lands in data low the next cycle and stays
// [RULE_15] firmware loads address low, clears both selects, then sets read
// [RULE_16] no eeprom write while the 64 ms power-up timer runs
// [RULE_17] with data protect at 0 only the cpu reaches the eeprom
// [RULE_18] cpu eeprom reads ignore the data protect bit
// [RULE_19] flash rows are 32 words aligned on address bits 4:0
// [RULE_20] eight 14-bit write latches aligned on address bits 2:0
// [RULE_21] firmware masks interrupts around unlock and commit
// [RULE_22] eeprom accesses use address low only
// [RULE_23] row erase stalls the cpu about 2 ms while clocks run
// [RULE_24] latch-only mode loads one latch; otherwise the block is programmed
// [RULE_25] after a block write every latch holds 3fffh
// [RULE_26] eeprom write time comes from a timer; strobe clears with done flag
module nvc_ctrl
	import nvc_pkg::*;
#(
	parameter int unsigned PWRT_CNT = PWRT_CYCLES,
	parameter int unsigned FLWR_CNT = FLWR_CYCLES,
	parameter int unsigned EEWR_CNT = EEWR_CYCLES
) (
	// apb slave
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// device reset request and configuration
	input  wire logic         dev_reset,
	input  wire logic         data_protect_n,
	input  wire logic         code_protect_n,
	input  wire logic [1:0]   self_program_protect_sel,
	// flash macro
	output logic      [14:0]  flash_addr,
	input  wire logic [13:0]  flash_rdata,
	output logic      [111:0] flash_wdata,
	output logic              flash_erase,
	output logic              flash_prog,
	output logic              cpu_stall,
	// programmer read path
	input  wire logic         ext_space,
	input  wire logic [7:0]   ext_addr,
	output logic      [7:0]   ext_rd_data,
	output logic              ext_grant
);
	nvc_ee_if ee ();

	nvc_op_t            op_reg;
	nvc_ulk_t           ulk_reg;
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   pwrt_cnt_reg;
	logic               pwrt_done_reg;
	logic               rd_reg;
	logic               wr_reg;
	logic               wallow_reg;
	logic               abort_reg;
	logic               free_reg;
	logic               lonly_reg;
	logic               csel_reg;
	logic               space_reg;
	logic               done_reg;
	logic [7:0]         dlo_reg;
	logic [5:0]         dhi_reg;
	logic [7:0]         alo_reg;
	logic [6:0]         ahi_reg;
	logic [7:0]         ee_wa_reg;
	logic [7:0]         ee_wd_reg;
	logic [13:0]        latch_reg [0:LATCHES-1];
	logic [14:0]        flash_addr_reg;
	logic               erase_reg;
	logic               prog_reg;
	logic               stall_reg;
	logic [31:0]        prdata_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic [7:0]         ext_rd_data_reg;
	logic               ext_grant_reg;

	// apb decode
	wire        acc      = psel & penable & pready_reg;
	wire        wr_acc   = acc & pwrite;
	wire        wr_ctrl  = wr_acc & (paddr == OFF_CTRL);
	wire        wr_ulk   = wr_acc & (paddr == OFF_UNLOCK);
	wire        wr_dlo   = wr_acc & (paddr == OFF_DLO);
	wire        wr_dhi   = wr_acc & (paddr == OFF_DHI);
	wire        wr_alo   = wr_acc & (paddr == OFF_ALO);
	wire        wr_ahi   = wr_acc & (paddr == OFF_AHI);
	wire        wr_irq   = wr_acc & (paddr == OFF_IRQ);
	wire        hit      = paddr inside {OFF_CTRL, OFF_UNLOCK, OFF_DLO, OFF_DHI,
	                                      OFF_ALO, OFF_AHI, OFF_IRQ, OFF_STAT};
	wire        op_idle  = (op_reg == OP_IDLE);
	wire        op_done  = !op_idle & (cnt_reg == '0);
	wire        armed    = (ulk_reg == UL_ARMED);
	wire        pw_space = pwdata[B_SPACE];
	wire        pw_csel  = pwdata[B_CSEL];
	wire        pw_free  = pwdata[B_FREE];
	wire        pw_latch = pwdata[B_LATCH];
	wire [14:0] faddr    = {ahi_reg, alo_reg};

	// self-write protect region
	wire [15:0] prot_lim = (self_program_protect_sel == 2'b11) ? PROT_NONE :
	                       (self_program_protect_sel == 2'b10) ? PROT_LOW :
	                       (self_program_protect_sel == 2'b01) ? PROT_HALF : PROT_ALL;
	wire        prot_hit = ({1'b0, faddr} < prot_lim);

	// writing zero to a strobe does nothing; a commit set is only taken while idle, a read set at any time dev_reset is low
	wire rd_go   = wr_ctrl & pwdata[B_RD] & !rd_reg & !dev_reset; // see [RULE_07]
	wire wr_req  = wr_ctrl & pwdata[B_WR] & !wr_reg & op_idle & !dev_reset; // see [RULE_07]
	wire wr_go   = wr_req & wallow_reg & armed; // see [RULE_09] see [RULE_13]
	wire ee_go   = wr_go & !pw_space & !pw_csel & pwrt_done_reg; // see [RULE_16] see [RULE_06]
	wire fl_go   = wr_go & pw_space & !pw_csel & !prot_hit; // see [RULE_04]
	wire fl_ltch = fl_go & pw_latch & !pw_free; // see [RULE_24]
	wire fl_long = fl_go & !fl_ltch;

	// read data: cpu eeprom reads ignore data protect
	wire [7:0] rd_lo = csel_reg ? 8'h00 : space_reg ? flash_rdata[7:0] : ee.rdata; // see [RULE_18]
	wire [5:0] rd_hi = csel_reg ? 6'h00 : flash_rdata[13:8];
	wire [7:0] ctrl_rd = {space_reg, csel_reg, lonly_reg, free_reg,
	                      abort_reg, wallow_reg, wr_reg, rd_reg};
	wire [31:0] rd_mux = (paddr == OFF_CTRL) ? {24'h0, ctrl_rd} :
	                     (paddr == OFF_DLO)  ? {24'h0, dlo_reg} :
	                     (paddr == OFF_DHI)  ? {26'h0, dhi_reg} :
	                     (paddr == OFF_ALO)  ? {24'h0, alo_reg} :
	                     (paddr == OFF_AHI)  ? {25'h0, ahi_reg} :
	                     (paddr == OFF_IRQ)  ? {31'h0, done_reg} :
	                     (paddr == OFF_STAT) ? {30'h0, pwrt_done_reg, !op_idle} :
	                     32'h0; // unlock port reads zero, see [RULE_12]

	// eeprom array hookup; only address low is used
	assign ee.raddr = alo_reg; // see [RULE_22]
	assign ee.we    = op_done & (op_reg == OP_EE) & !dev_reset;
	assign ee.waddr = ee_wa_reg;
	assign ee.wdata = ee_wd_reg;
	assign ee.xaddr = ext_addr;

	nvc_ee_array u_array (
		.pclk (pclk),
		.ee   (ee)
	);

	// apb answer: data captured in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= psel & !penable;
			pslverr_reg <= psel & !penable & !hit;
			if (psel & !penable) begin
				prdata_reg <= pwrite ? 32'h0 : rd_mux;
			end
		end
	end

	// unlock sequencer: any other write breaks the sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ulk_reg <= UL_IDLE;
		end else if (dev_reset) begin
			ulk_reg <= UL_IDLE;
		end else if (wr_ulk) begin
			case (ulk_reg)
				UL_FIRST: ulk_reg <= (pwdata[7:0] == UNLOCK_B) ? UL_ARMED :
				                     (pwdata[7:0] == UNLOCK_A) ? UL_FIRST : UL_IDLE; // see [RULE_13]
				default:  ulk_reg <= (pwdata[7:0] == UNLOCK_A) ? UL_FIRST : UL_IDLE;
			endcase
		end else if (wr_acc) begin
			ulk_reg <= UL_IDLE; // see [RULE_13]
		end
	end

	// power-up timer runs once after power-on reset only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwrt_cnt_reg  <= '0;
			pwrt_done_reg <= 1'b0;
		end else if (!pwrt_done_reg) begin
			if (pwrt_cnt_reg == CNT_W'(PWRT_CNT - 1)) begin
				pwrt_done_reg <= 1'b1; // see [RULE_16]
			end else begin
				pwrt_cnt_reg <= pwrt_cnt_reg + 1'b1;
			end
		end
	end

	// operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg <= OP_IDLE;
		end else begin
			case (op_reg)
				OP_IDLE: begin
					if (ee_go) begin
						op_reg <= OP_EE;
					end else if (fl_long) begin
						op_reg <= OP_FL;
					end
				end
				OP_EE, OP_FL: begin
					if (dev_reset | op_done) begin
						op_reg <= OP_IDLE;
					end
				end
				default: op_reg <= OP_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (ee_go) begin
			cnt_reg <= CNT_W'(EEWR_CNT - 1); // see [RULE_26]
		end else if (fl_long) begin
			cnt_reg <= CNT_W'(FLWR_CNT - 1); // see [RULE_23]
		end else if (!op_idle & (cnt_reg != '0)) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// strobes: a latch-only load shows wr for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			rd_reg <= rd_go; // see [RULE_07]
			if (dev_reset | op_done | (wr_reg & op_idle)) begin
				wr_reg <= 1'b0; // see [RULE_26]
			end else if (ee_go | fl_go) begin
				wr_reg <= 1'b1;
			end
		end
	end

	// control bits; write allow only ever cleared by power-on or software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wallow_reg <= 1'b0; // see [RULE_08]
			space_reg  <= 1'b0; // see [RULE_06]
			csel_reg   <= 1'b0;
			lonly_reg  <= 1'b0;
			free_reg   <= 1'b0;
		end else if (wr_ctrl) begin
			wallow_reg <= pwdata[B_WALW];
			space_reg  <= pw_space;
			csel_reg   <= pw_csel;
			lonly_reg  <= pw_latch;
			free_reg   <= pw_free;
		end else if (op_done & erase_reg) begin
			free_reg <= 1'b0;
		end
	end

	// sticky flags: the hardware set wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			if (dev_reset & !op_idle) begin
				abort_reg <= 1'b1; // see [RULE_10]
			end else if (wr_ctrl) begin
				abort_reg <= pwdata[B_ABORT];
			end
			if (op_done & !dev_reset) begin
				done_reg <= 1'b1; // see [RULE_11]
			end else if (wr_irq) begin
				done_reg <= pwdata[0];
			end
		end
	end

	// data and address holding registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dlo_reg <= 8'h00;
			dhi_reg <= 6'h00;
			alo_reg <= 8'h00;
			ahi_reg <= 7'h00;
		end else begin
			if (rd_reg) begin
				dlo_reg <= rd_lo; // see [RULE_14]
			end else if (wr_dlo) begin
				dlo_reg <= pwdata[7:0];
			end
			if (rd_reg & space_reg) begin
				dhi_reg <= rd_hi; // see [RULE_02]
			end else if (wr_dhi) begin
				dhi_reg <= pwdata[5:0];
			end
			if (wr_alo) begin
				alo_reg <= pwdata[7:0];
			end
			if (wr_ahi) begin
				ahi_reg <= pwdata[6:0];
			end
		end
	end

	// eeprom write target captured at commit so later register writes cannot move it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ee_wa_reg <= 8'h00;
			ee_wd_reg <= 8'h00;
		end else if (ee_go) begin
			ee_wa_reg <= alo_reg; // see [RULE_22]
			ee_wd_reg <= dlo_reg;
		end
	end

	// flash write latches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LATCHES; i++) begin
				latch_reg[i] <= LATCH_RST;
			end
		end else if (op_done & prog_reg) begin
			for (int i = 0; i < LATCHES; i++) begin
				latch_reg[i] <= LATCH_RST; // see [RULE_25]
			end
		end else if (fl_go & !pw_free) begin
			latch_reg[alo_reg[2:0]] <= {dhi_reg, dlo_reg}; // see [RULE_20]
		end
	end

	for (genvar g = 0; g < LATCHES; g++) begin : g_wdata
		assign flash_wdata[g*14 +: 14] = latch_reg[g];
	end

	// flash macro control; erase is row aligned, programming latch-block aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_addr_reg <= 15'h0000;
			erase_reg      <= 1'b0;
			prog_reg       <= 1'b0;
			stall_reg      <= 1'b0;
		end else begin
			if (rd_go & pw_space) begin
				flash_addr_reg <= faddr; // see [RULE_04]
			end else if (fl_long & pw_free) begin
				flash_addr_reg <= {faddr[14:5], 5'h00}; // see [RULE_19]
			end else if (fl_long) begin
				flash_addr_reg <= {faddr[14:3], 3'h0}; // see [RULE_20]
			end
			if (dev_reset | op_done) begin
				erase_reg <= 1'b0;
				prog_reg  <= 1'b0;
				stall_reg <= 1'b0;
			end else if (fl_long) begin
				erase_reg <= pw_free;
				prog_reg  <= !pw_free; // see [RULE_24]
				stall_reg <= 1'b1; // see [RULE_23]
			end
		end
	end

	// programmer path: code protect shuts both memories, data protect the eeprom
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_grant_reg   <= 1'b0;
			ext_rd_data_reg <= 8'h00;
		end else begin
			ext_grant_reg   <= code_protect_n & (ext_space | data_protect_n); // see [RULE_05]
			ext_rd_data_reg <= (code_protect_n & data_protect_n & !ext_space) ?
			                   ee.xdata : 8'h00; // see [RULE_17]
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign flash_addr  = flash_addr_reg;
	assign flash_erase = erase_reg;
	assign flash_prog  = prog_reg;
	assign cpu_stall   = stall_reg;
	assign ext_rd_data = ext_rd_data_reg;
	assign ext_grant   = ext_grant_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rd_next;
		rd_reg & !space_reg & !csel_reg & !dev_reset |=> (dlo_reg == $past(ee.rdata)) && !rd_reg;
	endproperty
	a_rd_next: assert property (p_rd_next) else $error("eeprom read data not loaded"); // see [RULE_14]

	property p_no_allow;
		wr_req & !wallow_reg |=> !wr_reg && op_idle;
	endproperty
	a_no_allow: assert property (p_no_allow) else $error("commit taken without write allow"); // see [RULE_09]

	property p_unlock_zero;
		acc & !pwrite & (paddr == OFF_UNLOCK) |-> prdata_reg == 32'h0;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero"); // see [RULE_12]

	property p_need_unlock;
		wr_req & (ulk_reg != UL_ARMED) |=> !wr_reg && op_idle;
	endproperty
	a_need_unlock: assert property (p_need_unlock) else $error("commit without unlock"); // see [RULE_13]

	property p_pwrt;
		!pwrt_done_reg |-> op_reg != OP_EE;
	endproperty
	a_pwrt: assert property (p_pwrt) else $error("eeprom write during power-up timer"); // see [RULE_16]

	property p_done;
		op_done & !dev_reset |=> done_reg && !wr_reg && op_idle;
	endproperty
	a_done: assert property (p_done) else $error("write end not flagged"); // see [RULE_11]

	property p_abort;
		dev_reset & !op_idle |=> abort_reg && op_idle && !wr_reg;
	endproperty
	a_abort: assert property (p_abort) else $error("interrupted write not flagged"); // see [RULE_10]

	property p_prot;
		wr_req & pw_space & prot_hit |=> !stall_reg && !prog_reg && !erase_reg;
	endproperty
	a_prot: assert property (p_prot) else $error("flash write into protected region"); // see [RULE_04]

	property p_allow_keep;
		wallow_reg & !wr_ctrl |=> wallow_reg;
	endproperty
	a_allow_keep: assert property (p_allow_keep) else $error("write allow cleared by hardware"); // see [RULE_08]

	property p_latch_clr;
		op_done & prog_reg & !dev_reset |=> latch_reg[0] == LATCH_RST && latch_reg[7] == LATCH_RST;
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latches not reset"); // see [RULE_25]
endmodule : nvc_ctrl

//--- test/nvc_flash_model.sv
/*
 flash macro model: answers a read word from the word address, combinationally.
 assumes the controller holds flash_addr steady while it loads the read data.
*/
`timescale 1ns/1ps
module nvc_flash_model (
	// flash macro side
	input  wire logic [14:0] flash_addr,
	output logic      [13:0] flash_rdata
);
	// pattern from address bits 13:0 only, so a wrong address in those bits shows up as wrong data
	assign flash_rdata = flash_addr[13:0] ^ 14'h1555;
endmodule : nvc_flash_model

//--- test/tb.sv
/*
 testbench for the nonvolatile access controller: apb tasks and directed tests.
 assumes the design answers apb with pready and shortened timing parameters.
*/
`timescale 1ns/1ps
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, v); end end
module tb
	import nvc_pkg::*;
;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, dev_reset;
	logic         data_protect_n, code_protect_n, flash_erase, flash_prog, cpu_stall;
	logic         ext_space, ext_grant, err;
	logic [1:0]   self_program_protect_sel;
	logic [7:0]   paddr, ext_addr, ext_rd_data;
	logic [31:0]  pwdata, prdata, r;
	logic [14:0]  flash_addr;
	logic [13:0]  flash_rdata;
	logic [111:0] flash_wdata;
	int           failures, checks;
	logic [7:0]   ea [3] = '{8'h00, 8'hff, 8'hff};
	logic [7:0]   ed [3] = '{8'hc3, 8'h3c, 8'ha5};
	nvc_ctrl #(.PWRT_CNT(20), .FLWR_CNT(10), .EEWR_CNT(10)) i_nvc_ctrl (.*);
	nvc_flash_model i_nvc_flash_model (.flash_addr(flash_addr), .flash_rdata(flash_rdata));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wt(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wt
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("read", e, r)
	endtask : rd
	// the other bits go first with both strobes masked off: the unlock pair must be the last writes before commit
	task automatic commit(input logic [31:0] v);
		wt(OFF_CTRL, v & 32'hfffffffc);
		wt(OFF_UNLOCK, 32'(UNLOCK_A));
		wt(OFF_UNLOCK, 32'(UNLOCK_B));
		wt(OFF_CTRL, v);
	endtask : commit
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_CTRL, 32'h0);
			n++;
		end while (r[B_WR] !== 1'b0 && n < 50);
		`CHK("idle", 1'b1, n < 50)
	endtask : wait_idle
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#40000;
		failures++;
		give_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, dev_reset, ext_space} = '0;
		{paddr, pwdata, ext_addr} = '0;
		{data_protect_n, code_protect_n} = 2'b11;
		self_program_protect_sel = 2'b11;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		commit(32'h06);
		rd(OFF_CTRL, 32'h04);
		rd(OFF_UNLOCK, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		`CHK("slverr", 1'b1, err)
		$display("test reset done");
		repeat (20) @(posedge pclk);
		rd(OFF_STAT, 32'h2);
		wt(OFF_CTRL, 32'h0);
		wt(OFF_UNLOCK, 32'(UNLOCK_A));
		wt(OFF_UNLOCK, 32'(UNLOCK_B));
		wt(OFF_CTRL, 32'h02);
		rd(OFF_CTRL, 32'h0);
		wt(OFF_CTRL, 32'h04);
		wt(OFF_UNLOCK, 32'(UNLOCK_B));
		wt(OFF_UNLOCK, 32'(UNLOCK_A));
		wt(OFF_CTRL, 32'h06);
		rd(OFF_CTRL, 32'h04);
		$display("test refusals done");
		wt(OFF_AHI, 32'h7f);
		// the last pass rewrites a byte, so a missing erase would leave old bits behind
		for (int i = 0; i < 3; i++) begin
			wt(OFF_ALO, 32'(ea[i]));
			wt(OFF_DLO, 32'(ed[i]));
			commit(32'h06);
			rd(OFF_CTRL, 32'h06);
			wt(OFF_CTRL, 32'h0);
			rd(OFF_CTRL, 32'h02);
			wait_idle();
			rd(OFF_IRQ, 32'h1);
			wt(OFF_IRQ, 32'h0);
			rd(OFF_IRQ, 32'h0);
			wt(OFF_DLO, 32'h0);
			wt(OFF_CTRL, 32'h01);
			rd(OFF_DLO, 32'(ed[i]));
			rd(OFF_CTRL, 32'h0);
		end
		$display("test eeprom done");
		ext_addr <= 8'hff;
		repeat (2) @(posedge pclk);
		`CHK("grant", 1'b1, ext_grant)
		`CHK("xdata", ed[2], ext_rd_data)
		data_protect_n <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("grant", 1'b0, ext_grant)
		`CHK("xdata", 8'h00, ext_rd_data)
		wt(OFF_CTRL, 32'h01);
		rd(OFF_DLO, 32'(ed[2]));
		code_protect_n <= 1'b0;
		ext_space <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK("grant", 1'b0, ext_grant)
		$display("test programmer done");
		wt(OFF_ALO, 32'h05);
		commit(32'h06);
		dev_reset <= 1'b1;
		@(posedge pclk);
		dev_reset <= 1'b0;
		rd(OFF_CTRL, 32'h0c);
		rd(OFF_IRQ, 32'h0);
		$display("test abort done");
		wt(OFF_AHI, 32'h12);
		wt(OFF_ALO, 32'h34);
		wt(OFF_CTRL, 32'h81);
		`CHK("faddr", 15'h1234, flash_addr)
		rd(OFF_DLO, 32'h61);
		rd(OFF_DHI, 32'h07);
		wt(OFF_ALO, 32'h03);
		wt(OFF_DHI, 32'h2a);
		wt(OFF_DLO, 32'h5b);
		commit(32'ha6);
		`CHK("latch", 14'h2a5b, flash_wdata[42 +: 14])
		`CHK("prog", 1'b0, flash_prog)
		commit(32'h86);
		`CHK("prog", 1'b1, flash_prog)
		`CHK("stall", 1'b1, cpu_stall)
		wait_idle();
		`CHK("latches", {8{LATCH_RST}}, flash_wdata)
		// row erase from a mid-row address: the macro must see the row base
		wt(OFF_ALO, 32'h3b);
		commit(32'h96);
		`CHK("erase", 1'b1, flash_erase)
		`CHK("faddr", 15'h1220, flash_addr)
		`CHK("stall", 1'b1, cpu_stall)
		wait_idle();
		`CHK("erase", 1'b0, flash_erase)
		rd(OFF_CTRL, 32'h84);
		self_program_protect_sel <= 2'b00;
		commit(32'h86);
		rd(OFF_CTRL, 32'h84);
		`CHK("prog", 1'b0, flash_prog)
		$display("test flash done");
		give_verdict();
	end
endmodule : tb
